// ### design/input_alarm_threshold_regs.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1: high threshold at byte addresses 24h-27h
// RULE2: hysteresis is upper six bits of top byte
// RULE3: host writes zeros to hysteresis low bits
// RULE4: high register bits 23-16 read zero
// RULE5: high limit is bits 15-0, resets FFFFh
// RULE6: low threshold at byte addresses 28h-2Bh
// RULE7: low register upper sixteen bits read zero
// RULE8: low limit is bits 15-0, resets zero
// RULE9: hysteresis byte resets to zero
// RULE10: overall alarm is OR of tripped flags
// RULE11: read-only active and tripped flags, high/low
// RULE12: compare each result with hysteresis release
module input_alarm_threshold_regs
  import iatr_pkg::*;
(
  input wire logic clk, // system clock, 50 MHz
  input wire logic rst_b, // async reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic resultValid, // one-cycle strobe, new conversion result
  input wire logic [15:0] result, // conversion result
  output logic [15:0] input_high_limit, // high threshold in use
  output logic [15:0] input_low_limit, // low threshold in use
  output logic [5:0] input_alarm_hysteresis, // hysteresis in use
  output logic latched_high_input_flag, // tripped high alarm
  output logic latched_low_input_flag, // tripped low alarm
  output logic overall_alarm_flag // OR of tripped alarms
);
  // ==========================================
  // register storage
  logic [15:0] highLimit; // high threshold field
  logic [15:0] lowLimit; // low threshold field
  logic [7:0] hystByte; // full hysteresis byte as written
  logic [15:0] next_highLimit;
  logic [15:0] next_lowLimit;
  logic [7:0] next_hystByte;
  iatr_cfg_s cfg; // configuration to comparator
  iatr_flags_s flags; // flags from comparator
  logic [31:0] statusWord; // assembled alarm status

  // ==========================================
  // write channel state
  logic awHeld; // write address captured
  logic wHeld; // write data captured
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic bValid;
  logic [1:0] bResp;
  logic next_awHeld;
  logic next_wHeld;
  logic [7:0] next_awAddr;
  logic [31:0] next_wData;
  logic [3:0] next_wStrb;
  logic next_bValid;
  logic [1:0] next_bResp;
  logic doWrite; // both halves present and no response pending

  // address and data are taken independently, in either order
  assign s_axi_awready = !awHeld;
  assign s_axi_wready = !wHeld;
  assign doWrite = awHeld && wHeld && !bValid;

  // write handshake and register update
  always_comb begin
    next_awHeld = awHeld;
    next_wHeld = wHeld;
    next_awAddr = awAddr;
    next_wData = wData;
    next_wStrb = wStrb;
    next_bValid = bValid;
    next_bResp = bResp;
    next_highLimit = highLimit;
    next_lowLimit = lowLimit;
    next_hystByte = hystByte;
    if (s_axi_awvalid && !awHeld) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHeld) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (bValid && s_axi_bready) begin
      next_bValid = 1'b0;
    end
    if (doWrite) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bValid = 1'b1;
      next_bResp = IATR_RESP_OKAY;
      case ({awAddr[7:2], 2'b00})
        IATR_HIGH_THRESHOLD_ADDR: begin // RULE1
          // byte lanes map onto byte addresses 24h..27h
          if (wStrb[0]) next_highLimit[7:0] = wData[7:0]; // RULE5
          if (wStrb[1]) next_highLimit[15:8] = wData[15:8]; // RULE5
          // lane 2 is reserved and ignored
          // low two bits are stored as written; host keeps them zero
          if (wStrb[3]) next_hystByte = wData[IATR_HYST_LSB +: 8]; // RULE3
        end
        IATR_LOW_THRESHOLD_ADDR: begin // RULE6
          if (wStrb[0]) next_lowLimit[7:0] = wData[7:0]; // RULE8
          if (wStrb[1]) next_lowLimit[15:8] = wData[15:8]; // RULE8
        end
        IATR_ALARM_STATUS_ADDR: begin
          // read-only; write accepted and dropped
        end
        default: begin
          next_bResp = IATR_RESP_SLVERR; // unmapped address
        end
      endcase
    end
  end

  // register write-side state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      bValid <= 1'b0;
      bResp <= IATR_RESP_OKAY;
      highLimit <= IATR_HIGH_LIMIT_RESET; // RULE5
      lowLimit <= IATR_LOW_LIMIT_RESET; // RULE8
      hystByte <= IATR_HYST_RESET; // RULE9
    end else begin
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awAddr <= next_awAddr;
      wData <= next_wData;
      wStrb <= next_wStrb;
      bValid <= next_bValid;
      bResp <= next_bResp;
      highLimit <= next_highLimit;
      lowLimit <= next_lowLimit;
      hystByte <= next_hystByte;
    end
  end

  assign s_axi_bvalid = bValid;
  assign s_axi_bresp = bResp;

  // ==========================================
  // read channel
  logic rValid;
  logic [31:0] rData;
  logic [1:0] rResp;
  logic next_rValid;
  logic [31:0] next_rData;
  logic [1:0] next_rResp;

  // one read at a time; address is refused while data waits
  assign s_axi_arready = !rValid;

  // status word: reserved bits zero
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[IATR_FLAG_ACT_HIGH] = flags.activeHigh; // RULE11
    statusWord[IATR_FLAG_ACT_LOW] = flags.activeLow; // RULE11
    statusWord[IATR_FLAG_TRIP_HIGH] = flags.latchedHigh; // RULE11
    statusWord[IATR_FLAG_TRIP_LOW] = flags.latchedLow; // RULE11
    statusWord[IATR_FLAG_OVERALL] = flags.latchedHigh | flags.latchedLow; // RULE10
  end

  // read decode, data registered for a clean output
  always_comb begin
    next_rValid = rValid;
    next_rData = rData;
    next_rResp = rResp;
    if (rValid && s_axi_rready) begin
      next_rValid = 1'b0;
    end
    if (s_axi_arvalid && !rValid) begin
      next_rValid = 1'b1;
      next_rResp = IATR_RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        IATR_HIGH_THRESHOLD_ADDR: begin
          next_rData = {hystByte, 8'h00, highLimit}; // RULE4
        end
        IATR_LOW_THRESHOLD_ADDR: begin
          next_rData = {16'h0000, lowLimit}; // RULE7
        end
        IATR_ALARM_STATUS_ADDR: begin
          next_rData = statusWord;
        end
        default: begin
          next_rData = 32'h0000_0000;
          next_rResp = IATR_RESP_SLVERR;
        end
      endcase
    end
  end

  // register read-side state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rValid <= 1'b0;
      rData <= 32'h0000_0000;
      rResp <= IATR_RESP_OKAY;
    end else begin
      rValid <= next_rValid;
      rData <= next_rData;
      rResp <= next_rResp;
    end
  end

  assign s_axi_rvalid = rValid;
  assign s_axi_rdata = rData;
  assign s_axi_rresp = rResp;

  // ==========================================
  // configuration and comparator
  assign cfg.highLimit = highLimit;
  assign cfg.lowLimit = lowLimit;
  assign cfg.hysteresis = hystByte[7:IATR_HYST_USED_LSB]; // RULE2

  iatr_compare compare (
    .clk(clk),
    .rst_b(rst_b),
    .resultValid(resultValid),
    .result(result),
    .cfg(cfg),
    .flags(flags)
  );

  assign input_high_limit = highLimit;
  assign input_low_limit = lowLimit;
  assign input_alarm_hysteresis = cfg.hysteresis;
  assign latched_high_input_flag = flags.latchedHigh;
  assign latched_low_input_flag = flags.latchedLow;
  assign overall_alarm_flag = flags.latchedHigh | flags.latchedLow; // RULE10
endmodule
`default_nettype wire

// ### include/iatr_pkg.sv
`default_nettype none
package iatr_pkg;
  // ==========================================
  // register byte addresses
  localparam logic [7:0] IATR_HIGH_THRESHOLD_ADDR = 8'h24;
  localparam logic [7:0] IATR_LOW_THRESHOLD_ADDR = 8'h28;
  localparam logic [7:0] IATR_ALARM_STATUS_ADDR = 8'h20;
  // ==========================================
  // reset values
  localparam logic [15:0] IATR_HIGH_LIMIT_RESET = 16'hFFFF;
  localparam logic [15:0] IATR_LOW_LIMIT_RESET = 16'h0000;
  localparam logic [7:0] IATR_HYST_RESET = 8'h00;
  // ==========================================
  // field positions
  localparam int IATR_HYST_LSB = 24;
  localparam int IATR_HYST_USED_LSB = 2;
  localparam int IATR_FLAG_TRIP_HIGH = 4;
  localparam int IATR_FLAG_TRIP_LOW = 5;
  localparam int IATR_FLAG_ACT_HIGH = 10;
  localparam int IATR_FLAG_ACT_LOW = 11;
  localparam int IATR_FLAG_OVERALL = 0;
  // ==========================================
  // AXI responses
  localparam logic [1:0] IATR_RESP_OKAY = 2'h0;
  localparam logic [1:0] IATR_RESP_SLVERR = 2'h2;

  // alarm configuration handed to the comparator
  typedef struct packed {
    logic [15:0] highLimit;
    logic [15:0] lowLimit;
    logic [5:0] hysteresis;
  } iatr_cfg_s;

  // alarm flags coming back from the comparator
  typedef struct packed {
    logic activeHigh;
    logic activeLow;
    logic latchedHigh;
    logic latchedLow;
  } iatr_flags_s;
endpackage
`default_nettype wire

// ### design/iatr_compare.sv
`timescale 1ns/1ps
`default_nettype none
module iatr_compare
  import iatr_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic resultValid, // one-cycle strobe with a new result
  input wire logic [15:0] result, // conversion result
  input wire iatr_cfg_s cfg, // thresholds and hysteresis
  output iatr_flags_s flags // alarm flags
);
  // ==========================================
  // hysteresis comparator
  logic activeHigh;
  logic activeLow;
  logic next_activeHigh;
  logic next_activeLow;
  logic [16:0] highRelease; // wide so a borrow out of the subtraction shows in bit 16
  logic [16:0] lowRelease;

  // compute next alarm states, only on a fresh result
  always_comb begin
    highRelease = {1'b0, cfg.highLimit} - {11'h000, cfg.hysteresis};
    lowRelease = {1'b0, cfg.lowLimit} + {11'h000, cfg.hysteresis};
    next_activeHigh = activeHigh;
    next_activeLow = activeLow;
    if (resultValid) begin
      // raise above limit, release below limit minus hysteresis, or on any result not above it when hysteresis exceeds limit
      if (result > cfg.highLimit) begin
        next_activeHigh = 1'b1; // RULE12
      end else if (highRelease[16] || ({1'b0, result} < highRelease)) begin
        next_activeHigh = 1'b0; // RULE12
      end
      if (result < cfg.lowLimit) begin
        next_activeLow = 1'b1; // RULE12
      end else if (!lowRelease[16] && ({1'b0, result} > lowRelease)) begin
        next_activeLow = 1'b0; // RULE12
      end
    end
  end

  // register the alarm states
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      activeHigh <= 1'b0;
      activeLow <= 1'b0;
    end else begin
      activeHigh <= next_activeHigh;
      activeLow <= next_activeLow;
    end
  end

  // tripped flags follow the hysteresis state; active ones are that state ANDed with the raw compare
  assign flags.latchedHigh = activeHigh; // RULE11
  assign flags.latchedLow = activeLow; // RULE11
  assign flags.activeHigh = activeHigh && (result > cfg.highLimit); // RULE11
  assign flags.activeLow = activeLow && (result < cfg.lowLimit); // RULE11
endmodule
`default_nettype wire

// ### sim/iatr_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module iatr_monitor
  import iatr_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_b, // reset, active low
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic resultValid, // result strobe
  input wire logic [15:0] result, // conversion result
  input wire logic [15:0] input_high_limit, // high limit
  input wire logic [15:0] input_low_limit, // low limit
  input wire logic [5:0] input_alarm_hysteresis, // hysteresis
  input wire logic latched_high_input_flag, // tripped high
  input wire logic latched_low_input_flag, // tripped low
  input wire logic overall_alarm_flag // overall alarm
);
  // ==========================================
  // address of the read being answered
  logic [7:0] readAddr; // last taken address
  logic [7:0] next_readAddr; // next value
  // capture only on the taking edge so the answer is tied to its request
  always_comb begin
    next_readAddr = readAddr;
    if (s_axi_arvalid && s_axi_arready) begin
      next_readAddr = s_axi_araddr;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readAddr <= 8'h00;
    end else begin
      readAddr <= next_readAddr;
    end
  end
  // ==========================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_reset_vals: assert property ($rose(rst_b) |-> input_high_limit == 16'hFFFF
    && input_low_limit == 16'h0000 && input_alarm_hysteresis == 6'h00) else $error("bad reset");
  chk_overall_or: assert property (overall_alarm_flag ==
    (latched_high_input_flag || latched_low_input_flag)) else $error("overall not OR");
  chk_trip_high: assert property (resultValid && result > input_high_limit
    |=> latched_high_input_flag) else $error("high not tripped");
  chk_trip_low: assert property (resultValid && result < input_low_limit
    |=> latched_low_input_flag) else $error("low not tripped");
  chk_flag_hold: assert property (!resultValid |=> $stable(latched_high_input_flag)
    && $stable(latched_low_input_flag)) else $error("flag moved");
  chk_high_read: assert property (s_axi_rvalid && readAddr == 8'h24 |->
    s_axi_rdata[15:0] == input_high_limit && s_axi_rdata[23:16] == 8'h00
    && s_axi_rdata[31:26] == input_alarm_hysteresis) else $error("high read");
  chk_low_read: assert property (s_axi_rvalid && readAddr == 8'h28 |->
    s_axi_rdata == {16'h0000, input_low_limit}) else $error("low read");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == IATR_RESP_SLVERR);
  cover property (latched_high_input_flag);
  cover property (latched_low_input_flag);
endmodule
bind input_alarm_threshold_regs iatr_monitor i_iatr_monitor (.*);
`default_nettype wire

// ### sim/input_alarm_threshold_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module input_alarm_threshold_regs_tb
  import iatr_pkg::*;
;
  // ==========================================
  // design signals, all inputs valued at time zero
  logic clk = 1'h0, rst_b = 1'h0, resultValid = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] result = 16'h0, input_high_limit, input_low_limit, r;
  logic [5:0] input_alarm_hysteresis;
  logic latched_high_input_flag, latched_low_input_flag, overall_alarm_flag;
  // ==========================================
  // expectation model
  logic [33:0] expq[$]; // expected {resp, data}, oldest first
  logic [31:0] hiReg, loReg, d; // register images
  logic th, tl; // tripped images
  logic [7:0] addrs[5] = '{8'h20, 8'h24, 8'h28, 8'h2C, 8'hFC};
  logic [15:0] vals[6] = '{16'h1001, 16'h0FFE, 16'h0FFB, 16'h00FF, 16'h0102, 16'h0105};
  int miscompares = 0, total_checks = 0, seed = 78;
  input_alarm_threshold_regs i_input_alarm_threshold_regs (.*);
  always #10 clk = ~clk; // 50 MHz
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  // answers are compared mid-cycle, where they are settled
  always @(negedge clk) begin
    if (s_axi_bvalid && s_axi_bready) check({s_axi_bresp, 32'h0}, expq.pop_front());
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, expq.pop_front());
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    logic ta, tw;
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    if (a == IATR_HIGH_THRESHOLD_ADDR) hiReg = (hiReg & ~m) | (v & m & 32'hFF00FFFF);
    if (a == IATR_LOW_THRESHOLD_ADDR) loReg = (loReg & ~m) | (v & m & 32'h0000FFFF);
    expq.push_back({(a inside {8'h20, 8'h24, 8'h28}) ? IATR_RESP_OKAY : IATR_RESP_SLVERR, 32'h0});
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    // each half is released at its own taking edge
    do begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end while (!((ta || !s_axi_awvalid) && (tw || !s_axi_wvalid)));
    do begin @(negedge clk); ta = s_axi_bvalid; @(posedge clk); end while (!ta);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic t;
    logic [31:0] st;
    st = 32'h0;
    st[IATR_FLAG_OVERALL] = th | tl;
    st[IATR_FLAG_TRIP_HIGH] = th;
    st[IATR_FLAG_TRIP_LOW] = tl;
    st[IATR_FLAG_ACT_HIGH] = th && result > hiReg[15:0];
    st[IATR_FLAG_ACT_LOW] = tl && result < loReg[15:0];
    case (a)
      IATR_HIGH_THRESHOLD_ADDR: expq.push_back({IATR_RESP_OKAY, hiReg});
      IATR_LOW_THRESHOLD_ADDR: expq.push_back({IATR_RESP_OKAY, loReg});
      IATR_ALARM_STATUS_ADDR: expq.push_back({IATR_RESP_OKAY, st});
      default: expq.push_back({IATR_RESP_SLVERR, 32'h0});
    endcase
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin @(negedge clk); t = s_axi_arready; @(posedge clk); end while (!t);
    s_axi_arvalid <= 1'h0;
    @(posedge clk);
    s_axi_rready <= 1'h1; // late on purpose, so read data must stand
    do begin @(negedge clk); t = s_axi_rvalid; @(posedge clk); end while (!t);
    s_axi_rready <= 1'h0;
  endtask
  task automatic conv(input logic [15:0] v);
    @(posedge clk);
    result <= v;
    resultValid <= 1'h1;
    if (v > hiReg[15:0]) th = 1'h1;
    // widened so a low limit near the top neither wraps nor releases falsely; a high limit under the hysteresis wraps and releases
    else if ({1'b0, v} < {1'b0, hiReg[15:0]} - hiReg[31:26]) th = 1'h0;
    if (v < loReg[15:0]) tl = 1'h1;
    else if ({1'b0, v} > {1'b0, loReg[15:0]} + hiReg[31:26]) tl = 1'h0;
    @(posedge clk);
    resultValid <= 1'h0;
  endtask
  task automatic reset_and_read();
    @(posedge clk);
    rst_b <= 1'h0;
    hiReg = 32'h0000FFFF;
    loReg = 32'h0;
    th = 1'h0;
    tl = 1'h0;
    repeat (5) @(posedge clk);
    rst_b <= 1'h1;
    foreach (addrs[i]) rd(addrs[i]);
    $display("reset test done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    end_of_test();
  end
  initial begin
    reset_and_read();
    // single lanes show where each byte lands; hysteresis low bits kept zero
    for (int k = 0; k < 4; k++) begin
      d = $random(seed);
      d[25:24] = 2'h0;
      wr(IATR_HIGH_THRESHOLD_ADDR, d, 4'h1 << k);
      wr(IATR_LOW_THRESHOLD_ADDR, ~d, 4'h1 << k);
      rd(IATR_HIGH_THRESHOLD_ADDR);
      rd(IATR_LOW_THRESHOLD_ADDR);
    end
    wr(IATR_ALARM_STATUS_ADDR, d, 4'hF);
    wr(8'h2C, d, 4'hF);
    foreach (addrs[i]) rd(addrs[i]);
    $display("lane test done");
    wr(IATR_HIGH_THRESHOLD_ADDR, 32'h10001000, 4'hF);
    wr(IATR_LOW_THRESHOLD_ADDR, 32'h00000100, 4'hF);
    for (int k = 0; k < 30; k++) begin
      r = (k < 6) ? vals[k] : 16'($unsigned($random(seed)) % 32'h1400);
      conv(r);
      rd(IATR_ALARM_STATUS_ADDR);
    end
    $display("alarm test done");
    reset_and_read();
    end_of_test();
  end
endmodule
`default_nettype wire
